// ### verilog/sac_pkg.sv
/*
  Constants and carrier types of the converter control block.
  Assumes one synchronous clock domain and a converter core that hands
  back a finished code when asked.
*/
// Operation
// - Conversion yields a 10-bit code, zero at ground, top code at reference.
// - One reference bit chooses supply pin or internal 1.1V reference.
// - Reference and channel writes reach the converter only while enabled.
// - Result right-aligned over two bytes, left-aligned when left-adjust set.
// - Reading low byte blocks result updates until high byte read.
// - Completion flag still rises when the blocked result is dropped.
// - Start write begins conversion; bit reads high until hardware clears it.
// - Channel change mid-conversion applies only after the running conversion.
// - Auto-trigger rising edge resets the prescaler and starts a conversion.
// - Trigger still high at end, or edges before a conversion's last 3 CPU cycles, start nothing.
// - Flags set even when masked; software clears trigger flag before next.
// - Own completion flag as trigger gives back-to-back free-running conversions.
// - Start write works under auto-trigger; start bit high during any conversion.
// - Prescaler divides CPU clock while enabled, held in reset otherwise.
// - Written start begins on the next converter clock rising edge.
// - Normal conversion 13 converter cycles, first after enabling 25.
// - Sample-and-hold at 1.5 cycles normally, 13.5 on the first.
// - At end write result, set flag, clear start bit in single mode.
// - Auto-trigger: hold at 2 cycles, 13.5 long, plus 3 CPU sync cycles.
// - Free running restarts at once, start high, hold 2.5, length 14.
// - Selections track writes, freeze in conversion, resume in last cycle.
package sac_pkg;
  localparam int CODE_W = 10;
  localparam int CHAN_W = 4;
  localparam int TSEL_W = 3;
  localparam int PSEL_W = 3;
  localparam int HALF_W = 6;
  localparam int SYNC_CYCLES = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_CLK_MIN_KHZ = 50;
  localparam int CONV_CLK_MAX_KHZ = 200;
  // trigger-select value that means the converter's own completion flag
  localparam logic [TSEL_W-1:0] FREE_RUN_TRIGGER = 3'h0;
  // sample-and-hold and end points, in converter half cycles from start
  localparam logic [HALF_W-1:0] SH_NORMAL = 6'h03;
  localparam logic [HALF_W-1:0] END_NORMAL = 6'h1a;
  localparam logic [HALF_W-1:0] SH_FIRST = 6'h1b;
  localparam logic [HALF_W-1:0] END_FIRST = 6'h32;
  localparam logic [HALF_W-1:0] SH_AUTO = 6'h04;
  localparam logic [HALF_W-1:0] END_AUTO = 6'h1b;
  localparam logic [HALF_W-1:0] SH_FREE = 6'h05;
  localparam logic [HALF_W-1:0] END_FREE = 6'h1c;
  localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;

  typedef enum logic [1:0] {SAC_SINGLE, SAC_FIRST, SAC_AUTO, SAC_FREE} sac_kind_e;

  typedef struct packed {
    logic enable;
    logic power_reduce;
    logic auto_trigger_enable;
    logic [TSEL_W-1:0] trigger_select;
    logic [PSEL_W-1:0] prescale_select;
    logic left_adjust;
    logic reference_select;
    logic [CHAN_W-1:0] channel_select;
  } sac_ctrl_s;

  typedef struct packed {
    logic start_write;
    logic flag_clear;
    logic read_low;
    logic read_high;
  } sac_sw_s;
endpackage

// ### verilog/sac_prescaler.sv
/*
  Power-of-two prescaler that marks converter clock edges.
  Assumes the caller only pulses clr_i while en_i is high.
*/
`timescale 1ns/100ps
module sac_prescaler #(
  parameter int PSEL_W = 3
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic [PSEL_W-1:0] psel_i,
  output logic rise_o,
  output logic half_o
);
  logic [8:0] div;
  logic [7:0] cnt;

  // ratio 2 to 256; a clear makes the current cycle a rising edge
  assign div = 9'h002 << psel_i;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !en_i) begin
      cnt <= 8'h00;
    end else if (clr_i) begin
      cnt <= 8'h01;
    end else if ({1'b0, cnt} == div - 9'h001) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // edge markers, silent while held off
  assign rise_o = en_i && (cnt == 8'h00);
  assign half_o = en_i && ((cnt == 8'h00) || ({1'b0, cnt} == (div >> 1)));

  property p_held_off;
    @(posedge clk_i) disable iff (!rst_b_i)
    !en_i |-> !half_o && !rise_o;
  endproperty
  a_held_off: assert property (p_held_off) else $error("prescaler ticks while off");
endmodule

// ### verilog/sac_control.sv
/*
  Conversion sequencer, selection buffer and result registers of the
  successive-approximation converter.
  Assumes software strobes arrive as one-cycle pulses and the analog core
  presents its finished code on core_code_i at the end of a conversion.
*/
`timescale 1ns/100ps
module sac_control #(
  parameter int TRIG_N = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire sac_pkg::sac_ctrl_s ctrl_i,
  input wire sac_pkg::sac_sw_s sw_i,
  input wire logic [TRIG_N-1:0] trigger_i,
  input wire logic [sac_pkg::CODE_W-1:0] core_code_i,
  output logic start_conversion_o,
  output logic conversion_done_flag_o,
  output logic [7:0] result_high_byte_o,
  output logic [7:0] result_low_byte_o,
  output logic sample_hold_o,
  output logic converter_clock_rise_o,
  output logic [sac_pkg::CHAN_W-1:0] channel_o,
  output logic reference_o
);
  typedef enum logic [1:0] {SAC_IDLE, SAC_WAIT, SAC_CONV} sac_state_e;

  // ==========================================================
  // helpers
  function automatic logic [sac_pkg::HALF_W-1:0] half_mark(sac_pkg::sac_kind_e k,
                                                           logic is_end);
    logic [sac_pkg::HALF_W-1:0] r;
    r = is_end ? sac_pkg::END_NORMAL : sac_pkg::SH_NORMAL;
    case (k)
      sac_pkg::SAC_FIRST: r = is_end ? sac_pkg::END_FIRST : sac_pkg::SH_FIRST;
      sac_pkg::SAC_AUTO: r = is_end ? sac_pkg::END_AUTO : sac_pkg::SH_AUTO;
      sac_pkg::SAC_FREE: r = is_end ? sac_pkg::END_FREE : sac_pkg::SH_FREE;
      default: r = is_end ? sac_pkg::END_NORMAL : sac_pkg::SH_NORMAL;
    endcase
    return r;
  endfunction

  // ==========================================================
  // declarations
  sac_state_e state;
  sac_pkg::sac_kind_e kind;
  logic on;
  logic rise;
  logic half;
  logic prev_trig;
  logic sel_lvl;
  logic free_sel;
  logic [sac_pkg::SYNC_CYCLES-1:0] trig_pipe;
  logic trig_go;
  logic launch;
  logic tick_end;
  logic free_restart;
  logic first;
  logic locked;
  logic track;
  logic [sac_pkg::HALF_W-1:0] hc;
  logic [sac_pkg::HALF_W-1:0] hc_next;
  logic [sac_pkg::HALF_W-1:0] end_half;
  logic [sac_pkg::CODE_W-1:0] code;

  // ==========================================================
  // prescaler and launch decisions
  // power reduction wins over enable: the core is unpowered
  assign on = ctrl_i.enable && !ctrl_i.power_reduce;

  sac_prescaler #(
    .PSEL_W(sac_pkg::PSEL_W)
  ) u_prescaler (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(on),
    .clr_i(trig_go),
    .psel_i(ctrl_i.prescale_select),
    .rise_o(rise),
    .half_o(half)
  );
  assign converter_clock_rise_o = rise;

  assign free_sel = ctrl_i.trigger_select == sac_pkg::FREE_RUN_TRIGGER;
  assign sel_lvl = trigger_i[ctrl_i.trigger_select];
  assign hc_next = hc + 6'h01;
  assign end_half = half_mark(kind, 1'b1);
  // start write takes precedence over a trigger arriving in the same cycle
  assign trig_go = on && state == SAC_IDLE && trig_pipe[sac_pkg::SYNC_CYCLES-1] &&
                   ctrl_i.auto_trigger_enable && !sw_i.start_write;
  assign tick_end = state == SAC_CONV && half && hc_next == end_half;
  assign free_restart = tick_end && ctrl_i.auto_trigger_enable && free_sel;
  assign launch = (state == SAC_WAIT && rise) || trig_go || free_restart;
  assign start_conversion_o = state != SAC_IDLE;

  // ==========================================================
  // trigger edge detection, delayed by the synchroniser cycles
  // edges seen while busy fall out unused, except in a conversion's last three CPU cycles, which launch once it ends
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prev_trig <= 1'b0;
      trig_pipe <= '0;
    end else begin
      prev_trig <= sel_lvl;
      trig_pipe <= {trig_pipe[sac_pkg::SYNC_CYCLES-2:0],
                    sel_lvl && !prev_trig && !free_sel && ctrl_i.auto_trigger_enable};
    end
  end

  // ==========================================================
  // sequencer state
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !on) begin
      state <= SAC_IDLE;
    end else begin
      case (state)
        SAC_IDLE: begin
          if (sw_i.start_write) begin
            state <= SAC_WAIT;
          end else if (trig_go) begin
            state <= SAC_CONV;
          end
        end
        SAC_WAIT: begin
          if (rise) begin
            state <= SAC_CONV;
          end
        end
        SAC_CONV: begin
          // a level still high at the end does not relaunch
          if (tick_end && !free_restart) begin
            state <= SAC_IDLE;
          end
        end
        default: state <= SAC_IDLE;
      endcase
    end
  end

  // half-cycle count from the launching converter clock edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hc <= '0;
    end else if (launch) begin
      hc <= '0;
    end else if (state == SAC_CONV && half) begin
      hc <= hc_next;
    end
  end

  // timing class of the running conversion
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      kind <= sac_pkg::SAC_SINGLE;
    end else if (free_restart) begin
      kind <= sac_pkg::SAC_FREE;
    end else if (launch && first) begin
      kind <= sac_pkg::SAC_FIRST;
    end else if (launch && trig_go) begin
      kind <= sac_pkg::SAC_AUTO;
    end else if (launch) begin
      kind <= sac_pkg::SAC_SINGLE;
    end
  end

  // first conversion after switching on warms up the analog side
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !on) begin
      first <= 1'b1;
    end else if (tick_end) begin
      first <= 1'b0;
    end
  end

  // sample-and-hold strobe, one CPU cycle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sample_hold_o <= 1'b0;
    end else begin
      sample_hold_o <= state == SAC_CONV && half && hc_next == half_mark(kind, 1'b0);
    end
  end

  // ==========================================================
  // selection buffer
  // frozen during a conversion until its last converter cycle, so a mid-conversion write lands on the next one
  assign track = on && (state != SAC_CONV || hc >= end_half - 6'h02);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      channel_o <= '0;
      reference_o <= 1'b0;
    end else if (track) begin
      channel_o <= ctrl_i.channel_select;
      reference_o <= ctrl_i.reference_select;
    end
  end

  // ==========================================================
  // completion flag; a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      conversion_done_flag_o <= 1'b0;
    end else if (tick_end) begin
      conversion_done_flag_o <= 1'b1;
    end else if (sw_i.flag_clear) begin
      conversion_done_flag_o <= 1'b0;
    end
  end

  // read lock between low-byte and high-byte reads
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      locked <= 1'b0;
    end else if (sw_i.read_high) begin
      locked <= 1'b0;
    end else if (sw_i.read_low) begin
      locked <= 1'b1;
    end
  end

  // captured code; a result finishing under the lock is lost
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      code <= sac_pkg::CODE_RESET;
    end else if (tick_end && !locked) begin
      code <= core_code_i;
    end
  end

  // byte view follows the alignment bit one cycle later
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      result_high_byte_o <= 8'h00;
      result_low_byte_o <= 8'h00;
    end else if (ctrl_i.left_adjust) begin
      result_high_byte_o <= code[9:2];
      result_low_byte_o <= {code[1:0], 6'h00};
    end else begin
      result_high_byte_o <= {6'h00, code[9:8]};
      result_low_byte_o <= code[7:0];
    end
  end

  // ==========================================================
  // checks
  property p_start_high;
    @(posedge clk_i) disable iff (!rst_b_i)
    on && state == SAC_IDLE && sw_i.start_write ##1 on |-> start_conversion_o;
  endproperty
  a_start_high: assert property (p_start_high) else $error("start bit not high");

  property p_flag_set;
    @(posedge clk_i) disable iff (!rst_b_i)
    tick_end |=> conversion_done_flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag missed");

  property p_lock_holds;
    @(posedge clk_i) disable iff (!rst_b_i)
    locked && !sw_i.read_high && !ctrl_i.left_adjust ##1 !ctrl_i.left_adjust
      |=> $stable(result_low_byte_o);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("result changed while locked");

  property p_single_clears;
    @(posedge clk_i) disable iff (!rst_b_i)
    tick_end && !free_restart |=> !start_conversion_o;
  endproperty
  a_single_clears: assert property (p_single_clears) else $error("start bit not cleared");

  property p_free_runs;
    @(posedge clk_i) disable iff (!rst_b_i)
    free_restart && on ##1 on |-> start_conversion_o && hc == 6'h00;
  endproperty
  a_free_runs: assert property (p_free_runs) else $error("free run stopped");

  property p_frozen;
    @(posedge clk_i) disable iff (!rst_b_i)
    state == SAC_CONV && !track |=> $stable(channel_o) && $stable(reference_o);
  endproperty
  a_frozen: assert property (p_frozen) else $error("selection moved mid conversion");

  property p_off_no_update;
    @(posedge clk_i) disable iff (!rst_b_i)
    !on |=> $stable(channel_o) && !start_conversion_o;
  endproperty
  a_off_no_update: assert property (p_off_no_update) else $error("acted while off");

  property p_edge_ignored;
    @(posedge clk_i) disable iff (!rst_b_i)
    state == SAC_CONV && !tick_end && trig_pipe[sac_pkg::SYNC_CYCLES-1] |=> hc != 6'h00;
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("edge restarted conversion");

  property p_left_pad;
    @(posedge clk_i) disable iff (!rst_b_i)
    ctrl_i.left_adjust |=> result_low_byte_o[5:0] == 6'h00;
  endproperty
  a_left_pad: assert property (p_left_pad) else $error("left alignment wrong");

  property p_hold_inside;
    @(posedge clk_i) disable iff (!rst_b_i)
    sample_hold_o |-> $past(state) == SAC_CONV && $past(hc_next) < $past(end_half);
  endproperty
  a_hold_inside: assert property (p_hold_inside) else $error("hold outside conversion");

  property p_trig_launch;
    @(posedge clk_i) disable iff (!rst_b_i)
    trig_go |=> state == SAC_CONV && hc == 6'h00;
  endproperty
  a_trig_launch: assert property (p_trig_launch) else $error("trigger did not launch");

  property p_wait_launch;
    @(posedge clk_i) disable iff (!rst_b_i)
    state == SAC_WAIT && rise |=> state == SAC_CONV && hc == 6'h00;
  endproperty
  a_wait_launch: assert property (p_wait_launch) else $error("start missed edge");

  property p_lost_result;
    @(posedge clk_i) disable iff (!rst_b_i)
    tick_end && locked |=> $stable(code);
  endproperty
  a_lost_result: assert property (p_lost_result) else $error("lock overwritten");

  property p_first_long;
    @(posedge clk_i) disable iff (!rst_b_i)
    launch && first && !free_restart |=> kind == sac_pkg::SAC_FIRST;
  endproperty
  a_first_long: assert property (p_first_long) else $error("first not long");

  property p_free_kind;
    @(posedge clk_i) disable iff (!rst_b_i)
    free_restart |=> kind == sac_pkg::SAC_FREE;
  endproperty
  a_free_kind: assert property (p_free_kind) else $error("free run timing not used");

  property p_track_end;
    @(posedge clk_i) disable iff (!rst_b_i)
    on && tick_end |=> channel_o == $past(ctrl_i.channel_select);
  endproperty
  a_track_end: assert property (p_track_end) else $error("selection not resumed");
endmodule

// ### tb/sac_control_bench.sv
/*
  Self-checking bench for the converter control block: a table of single
  conversions, then hand-written cases for lock, selections and triggers.
  Assumes the prescaler runs at ratio 2 so one half edge falls each cycle.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module sac_control_bench;
  typedef struct packed {logic [9:0] code; logic left; logic fst;} sac_row_s;
  logic clk_i;
  logic rst_b_i;
  sac_pkg::sac_ctrl_s ctrl;
  sac_pkg::sac_sw_s sw;
  logic [7:0] trig;
  logic [9:0] code;
  logic start_conversion_o, conversion_done_flag_o, sample_hold_o, rise_o, reference_o;
  logic [7:0] result_high_byte_o, result_low_byte_o;
  logic [3:0] channel_o;
  logic [15:0] res;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0, t_r0 = 0, t_sh = 0, t_sh0 = 0, t_fl = 0, t_rise = 0, t_rp = 0;
  logic armed = 1'b0, flag_d = 1'b0;
  sac_row_s rows [5] = '{'{10'h3ff, 1'b0, 1'b1}, '{10'h2a5, 1'b0, 1'b0},
    '{10'h2a5, 1'b1, 1'b0}, '{10'h001, 1'b1, 1'b0}, '{10'h000, 1'b0, 1'b0}};

  sac_control #(.TRIG_N(8)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .ctrl_i(ctrl),
    .sw_i(sw), .trigger_i(trig), .core_code_i(code),
    .start_conversion_o(start_conversion_o), .conversion_done_flag_o(conversion_done_flag_o),
    .result_high_byte_o(result_high_byte_o), .result_low_byte_o(result_low_byte_o),
    .sample_hold_o(sample_hold_o), .converter_clock_rise_o(rise_o),
    .channel_o(channel_o), .reference_o(reference_o));
  assign res = {result_high_byte_o, result_low_byte_o};

  // ==========================================================
  // clock and event stamps
  // ==========================================================
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // stamps are taken before each edge's updates, so registered outputs show one
  // edge late; the launch stamp is moved one cycle on to share that offset
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (start_conversion_o !== 1'b1) armed <= 1'b0;
    else if (rise_o === 1'b1 && !armed) begin
      armed <= 1'b1;
      t_r0 <= cyc + 1;
    end
    if (sample_hold_o === 1'b1) begin
      t_sh0 <= t_sh;
      t_sh <= cyc;
    end
    if (conversion_done_flag_o === 1'b1 && flag_d !== 1'b1) t_fl <= cyc;
    flag_d <= conversion_done_flag_o;
    if (rise_o === 1'b1) begin
      t_rp <= t_rise;
      t_rise <= cyc;
    end
  end

  // ==========================================================
  // driver tasks
  // ==========================================================
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // strobes are one cycle wide; bit order start, clear, read low, read high
  // an idle cycle follows, so back-to-back calls never re-raise in one step
  task automatic pulse_sw(input logic [3:0] s);
    sw = s;
    tick(1);
    sw = '0;
    tick(1);
  endtask

  // bounded wait, then one more edge so stamps and bytes have landed
  task automatic wait_flag();
    int k;
    for (k = 0; k < 2000 && conversion_done_flag_o !== 1'b1; k++) tick(1);
    tick(1);
    `CHK("done_flag", 1'b1, conversion_done_flag_o)
  endtask

  function automatic logic [15:0] fmt(input logic [9:0] c, input logic l);
    return l ? {c, 6'h00} : {6'h00, c};
  endfunction

  task automatic end_of_test();
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // a hang counts as a mismatch; the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    int i;
    rst_b_i = 1'b0;
    ctrl = '0;
    sw = '0;
    trig = '0;
    code = '0;
    ctrl.channel_select = 4'h5;
    ctrl.reference_select = 1'b1;
    tick(8);
    `CHK("rst_a", 3'h0, {start_conversion_o, conversion_done_flag_o, sample_hold_o})
    `CHK("rst_b", 22'h0, {res, channel_o, reference_o, rise_o})
    tick(8);
    rst_b_i = 1'b1;
    // disabled: selections frozen, prescaler still; under power reduction: start refused
    tick(4);
    `CHK("sel_off", 5'h00, {channel_o, reference_o})
    `CHK("presc_off", 0, t_rise)
    ctrl.enable = 1'b1;
    ctrl.power_reduce = 1'b1;
    pulse_sw(4'h8);
    tick(2);
    `CHK("start_pr", 1'b0, start_conversion_o)
    ctrl.power_reduce = 1'b0;
    tick(3);
    `CHK("sel_on", 5'h0b, {channel_o, reference_o})
    for (i = 0; i < 4; i++) begin
      ctrl.prescale_select = i[2:0];
      tick((4 << i) + 4);
      `CHK("presc_ratio", 2 << i, t_rise - t_rp)
    end
    // fastest ratio: this bench needs no full resolution, so the slow converter
    // clock window that software keeps for accurate codes is not kept here
    ctrl.prescale_select = 3'h0;
    tick(2);
    // table of single conversions; the first row is the first after enabling
    for (i = 0; i < 5; i++) begin
      ctrl.left_adjust = rows[i].left;
      code = rows[i].code;
      pulse_sw(4'h8);
      `CHK("start_high", 1'b1, start_conversion_o)
      pulse_sw(4'h8);
      wait_flag();
      `CHK("conv_len", rows[i].fst ? 2 * 25 : 2 * 13, t_fl - t_r0)
      `CHK("sh_point", rows[i].fst ? 27 : 3, t_sh - t_r0)
      `CHK("start_clr", 1'b0, start_conversion_o)
      `CHK("bytes", fmt(rows[i].code, rows[i].left), res)
      pulse_sw(4'h2);
      pulse_sw(4'h1);
      pulse_sw(4'h4);
      `CHK("flag_clr", 1'b0, conversion_done_flag_o)
    end
    // low byte read blocks updates; flag still rises
    pulse_sw(4'h2);
    code = 10'h155;
    pulse_sw(4'h8);
    wait_flag();
    `CHK("locked", 16'h0000, {result_high_byte_o, result_low_byte_o})
    pulse_sw(4'h1);
    pulse_sw(4'h4);
    // channel change mid-conversion waits for the end
    ctrl.channel_select = 4'h3;
    tick(2);
    pulse_sw(4'h8);
    tick(3);
    ctrl.channel_select = 4'h9;
    tick(5);
    `CHK("ch_frozen", 4'h3, channel_o)
    wait_flag();
    `CHK("unlocked", 16'h0155, {result_high_byte_o, result_low_byte_o})
    tick(1);
    `CHK("ch_new", 4'h9, channel_o)
    pulse_sw(4'h4);
    // auto trigger on source 3
    ctrl.auto_trigger_enable = 1'b1;
    ctrl.trigger_select = 3'h3;
    trig[3] = 1'b1;
    wait_flag();
    `CHK("auto_tail", 23, t_fl - t_sh)
    `CHK("auto_start", 1'b0, start_conversion_o)
    pulse_sw(4'h4);
    trig[3] = 1'b0;
    tick(2);
    trig[3] = 1'b1;
    tick(12);
    trig[3] = 1'b0;
    tick(1);
    trig[3] = 1'b1;
    wait_flag();
    pulse_sw(4'h4);
    tick(80);
    `CHK("no_retrig", 2'b00, {start_conversion_o, conversion_done_flag_o})
    // start write still launches a plain single conversion
    pulse_sw(4'h8);
    wait_flag();
    `CHK("auto_single", 26, t_fl - t_r0)
    pulse_sw(4'h4);
    // own flag as trigger: free run without clearing the flag
    ctrl.trigger_select = 3'h0;
    trig = '0;
    pulse_sw(4'h8);
    wait_flag();
    tick(60);
    `CHK("free_period", 28, t_sh - t_sh0)
    `CHK("free_start", 1'b1, start_conversion_o)
    end_of_test();
  end
endmodule
